//--- rtl/two_level_irq_unit.sv
// two-level interrupt priority unit: flags, enables, vectoring, return
// assumes one core clock per instruction cycle and a register port master
`timescale 1ns/1ps
`default_nettype none
`include "irq_unit_consts.svh"

// Summary of operation
// - each source high or low, two vectors
// - high preempts low service, never reverse
// - per source flag, enable, priority bits
// - priority mode bit, cleared at reset
// - priority mode: bit7 high, bit6 low enable
// - flag, enable, global enable vector at once
// - compatibility mode ignores priority bits
// - compatibility: bit6 peripherals, bit7 all
// - compatibility mode vectors only to high
// - entry clears the governing global enable
// - entry pushes return, loads vector
// - return pops, sets governing enable
// - pin events reach vector fixed latency
// - flags set regardless of the interrupt enables
// - edge select one rising, zero falling
// - port mismatch keeps flag set; read ends
module two_level_irq_unit (
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	input  wire logic        CE,
	input  wire logic [3:0]  ADDR,
	input  wire logic [7:0]  WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [7:0]  RDATA,
	input  wire logic [3:0]  EXT_PIN,
	input  wire logic [3:0]  PORT_PIN,
	input  wire logic [2:0]  PERIPH_EVT,
	input  wire logic        RETURN_EXEC,
	output logic             IRQ,
	output logic             PC_LOAD,
	output logic      [20:0] PC_VECTOR,
	output logic             STACK_PUSH,
	output logic             STACK_POP,
	output logic      [1:0]  ENTRY_LEVEL
);
	logic [3:0] ext_level;
	logic [3:0] ext_prev;
	logic [3:0] ext_hit;
	logic [3:0] port_level;
	logic [3:0] port_latched;
	logic       port_mismatch;
	logic [7:0] sets;
	logic [7:0] flag;
	logic [7:0] enable;
	logic [7:0] priority_sel;
	logic [3:0] ext_irq_edge_select;
	logic       priority_mode_enable;
	logic       high_level_global_enable;
	logic       low_level_global_enable;
	logic       in_high;
	logic       in_low;
	logic [7:0] pend;
	logic       hi_req;
	logic       lo_req;
	logic       cm_req;
	logic [2:0] status;
	logic [2:0] mask;
	logic [2:0] ev;
	logic [7:0] next_rdata;
	irq_unit_pkg::entry_level_e next_level;

	pin_sync #(.WIDTH(4)) u_ext_sync (
		.CORE_CLK (CORE_CLK),
		.RST      (RST),
		.CE       (CE),
		.PIN      (EXT_PIN),
		.LEVEL    (ext_level)
	);

	pin_sync #(.WIDTH(4)) u_port_sync (
		.CORE_CLK (CORE_CLK),
		.RST      (RST),
		.CE       (CE),
		.PIN      (PORT_PIN),
		.LEVEL    (port_level)
	);

	port_change_detect u_port_change (
		.CORE_CLK  (CORE_CLK),
		.RST       (RST),
		.CE        (CE),
		.LEVEL     (port_level),
		.PORT_READ (RD && ADDR == `OFS_PORT_B),
		.LATCHED   (port_latched),
		.MISMATCH  (port_mismatch)
	);

	// edge detection on settled pin levels
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ext_prev <= 4'h0;
		end else if (CE) begin
			ext_prev <= ext_level;
		end
	end

	assign ext_hit = (ext_irq_edge_select & ext_level & ~ext_prev)
		| (~ext_irq_edge_select & ~ext_level & ext_prev);
	assign sets = {PERIPH_EVT, port_mismatch, ext_hit};

	// flags set on events whatever the enables; set wins over a write
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			flag <= 8'h00;
		end else if (CE) begin
			if (WR && ADDR == `OFS_FLAG) begin
				flag <= WDATA | sets;
			end else begin
				flag <= flag | sets;
			end
		end
	end

	// per source enable, priority and edge controls
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			enable              <= 8'h00;
			priority_sel        <= `RST_PRIORITY;
			ext_irq_edge_select <= `RST_EDGE_SELECT;
			mask                <= 3'h0;
		end else if (CE && WR) begin
			if (ADDR == `OFS_ENABLE) begin
				enable <= WDATA;
			end
			if (ADDR == `OFS_PRIORITY) begin
				priority_sel <= WDATA;
			end
			if (ADDR == `OFS_EDGE_SELECT) begin
				ext_irq_edge_select <= WDATA[3:0];
			end
			if (ADDR == `OFS_MASK) begin
				mask <= WDATA[2:0];
			end
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			priority_mode_enable <= 1'b0;
		end else if (CE && WR && ADDR == `OFS_RESET_CONTROL) begin
			priority_mode_enable <= WDATA[`BIT_PRIO_MODE];
		end
	end

	// request evaluation
	assign pend   = flag & enable;
	assign hi_req = priority_mode_enable && high_level_global_enable
		&& |(pend & priority_sel);
	assign lo_req = priority_mode_enable && high_level_global_enable
		&& low_level_global_enable && |(pend & ~priority_sel) && !hi_req;
	assign cm_req = !priority_mode_enable && high_level_global_enable
		&& |(pend & (`CORE_SRC_MASK | {8{low_level_global_enable}}));

	always_comb begin
		next_level = irq_unit_pkg::LVL_NONE;
		if (hi_req) begin
			next_level = irq_unit_pkg::LVL_HIGH;
		end else if (lo_req) begin
			next_level = irq_unit_pkg::LVL_LOW;
		end else if (cm_req) begin
			next_level = irq_unit_pkg::LVL_COMPAT;
		end
	end

	// global enables: software write, return restore, entry clear
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			high_level_global_enable <= 1'b0;
			low_level_global_enable  <= 1'b0;
		end else if (CE) begin
			if (WR && ADDR == `OFS_IRQ_CONTROL) begin
				high_level_global_enable <= WDATA[`BIT_GLOBAL_HIGH];
				low_level_global_enable  <= WDATA[`BIT_PERIPH_LOW];
			end
			if (RETURN_EXEC) begin
				if (!priority_mode_enable || in_high) begin
					high_level_global_enable <= 1'b1;
				end else begin
					low_level_global_enable <= 1'b1;
				end
			end
			unique case (next_level)
				irq_unit_pkg::LVL_HIGH,
				irq_unit_pkg::LVL_COMPAT: high_level_global_enable <= 1'b0;
				irq_unit_pkg::LVL_LOW:    low_level_global_enable  <= 1'b0;
				irq_unit_pkg::LVL_NONE: begin
				end
			endcase
		end
	end

	// service level tracking for nested return
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			in_high <= 1'b0;
			in_low  <= 1'b0;
		end else if (CE) begin
			if (RETURN_EXEC) begin
				if (in_high) begin
					in_high <= 1'b0;
				end else begin
					in_low <= 1'b0;
				end
			end
			if (next_level == irq_unit_pkg::LVL_HIGH || next_level == irq_unit_pkg::LVL_COMPAT) begin
				in_high <= 1'b1;
			end
			if (next_level == irq_unit_pkg::LVL_LOW) begin
				in_low <= 1'b1;
			end
		end
	end

	// core sequencer strobes
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			PC_LOAD     <= 1'b0;
			STACK_PUSH  <= 1'b0;
			STACK_POP   <= 1'b0;
			PC_VECTOR   <= 21'h000000;
			ENTRY_LEVEL <= 2'h0;
		end else if (CE) begin
			PC_LOAD     <= (next_level != irq_unit_pkg::LVL_NONE);
			STACK_PUSH  <= (next_level != irq_unit_pkg::LVL_NONE);
			STACK_POP   <= RETURN_EXEC;
			ENTRY_LEVEL <= next_level;
			if (next_level == irq_unit_pkg::LVL_LOW) begin
				PC_VECTOR <= `VEC_LOW;
			end else if (next_level != irq_unit_pkg::LVL_NONE) begin
				PC_VECTOR <= `VEC_HIGH;
			end
		end
	end

	// sticky event status, cleared by read, set wins
	assign ev = {RETURN_EXEC, next_level == irq_unit_pkg::LVL_LOW,
		next_level == irq_unit_pkg::LVL_HIGH || next_level == irq_unit_pkg::LVL_COMPAT};

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			status <= 3'h0;
			IRQ    <= 1'b0;
		end else if (CE) begin
			if (RD && ADDR == `OFS_STATUS) begin
				status <= ev;
			end else begin
				status <= status | ev;
			end
			IRQ <= |(status & mask);
		end
	end

	// register read port
	always_comb begin
		next_rdata = 8'h00;
		unique case (ADDR)
			`OFS_IRQ_CONTROL:   next_rdata = {high_level_global_enable, low_level_global_enable, 6'h00};
			`OFS_RESET_CONTROL: next_rdata = {priority_mode_enable, 7'h00};
			`OFS_FLAG:          next_rdata = flag;
			`OFS_ENABLE:        next_rdata = enable;
			`OFS_PRIORITY:      next_rdata = priority_sel;
			`OFS_EDGE_SELECT:   next_rdata = {4'h0, ext_irq_edge_select};
			`OFS_PORT_B:        next_rdata = {port_level, 4'h0};
			`OFS_STATUS:        next_rdata = {5'h00, status};
			`OFS_MASK:          next_rdata = {5'h00, mask};
			default:            next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			RDATA <= 8'h00;
		end else if (CE) begin
			RDATA <= RD ? next_rdata : 8'h00;
		end
	end

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);

	property p_high_vector;
		CE && hi_req |=> PC_LOAD && STACK_PUSH && PC_VECTOR == `VEC_HIGH;
	endproperty
	a_high_vector: assert property (p_high_vector) else $error("high entry wrong");

	property p_low_vector;
		CE && lo_req |=> PC_LOAD && PC_VECTOR == `VEC_LOW && !low_level_global_enable;
	endproperty
	a_low_vector: assert property (p_low_vector) else $error("low entry wrong");

	property p_preempt;
		CE && in_low && !in_high && hi_req |=> PC_LOAD && in_high && PC_VECTOR == `VEC_HIGH;
	endproperty
	a_preempt: assert property (p_preempt) else $error("no preemption");

	property p_compat_vector;
		CE && cm_req |=> PC_VECTOR == `VEC_HIGH && !high_level_global_enable;
	endproperty
	a_compat_vector: assert property (p_compat_vector) else $error("compat entry wrong");

	property p_compat_no_low;
		!priority_mode_enable |-> !lo_req && !hi_req;
	endproperty
	a_compat_no_low: assert property (p_compat_no_low) else $error("priority used");

	property p_return_low;
		CE && RETURN_EXEC && priority_mode_enable && !in_high && next_level == irq_unit_pkg::LVL_NONE
			|=> low_level_global_enable && STACK_POP;
	endproperty
	a_return_low: assert property (p_return_low) else $error("low return wrong");

	property p_flag_set;
		CE && ext_hit[0] |=> flag[0];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set");

	property p_port_change;
		CE && port_mismatch |=> flag[`BIT_PORT_CHANGE];
	endproperty
	a_port_change: assert property (p_port_change) else $error("port flag lost");

	property p_enable_block;
		CE && pend == 8'h00 |=> !PC_LOAD;
	endproperty
	a_enable_block: assert property (p_enable_block) else $error("entry without enable");

	property p_return_high;
		CE && RETURN_EXEC && (!priority_mode_enable || in_high) && next_level == irq_unit_pkg::LVL_NONE
			|=> high_level_global_enable && STACK_POP;
	endproperty
	a_return_high: assert property (p_return_high) else $error("high return wrong");

	property p_falling_edge;
		CE && !ext_irq_edge_select[1] && !ext_level[1] && ext_prev[1] |=> flag[1];
	endproperty
	a_falling_edge: assert property (p_falling_edge) else $error("falling edge missed");
endmodule
`default_nettype wire

//--- rtl/irq_unit_consts.svh
// register offsets, field positions, reset values and vector addresses
// assumes inclusion by the interrupt unit design files and its test bench
`ifndef IRQ_UNIT_CONSTS_SVH
`define IRQ_UNIT_CONSTS_SVH

`define OFS_IRQ_CONTROL   4'h0
`define OFS_RESET_CONTROL 4'h1
`define OFS_FLAG          4'h2
`define OFS_ENABLE        4'h3
`define OFS_PRIORITY      4'h4
`define OFS_EDGE_SELECT   4'h5
`define OFS_PORT_B        4'h6
`define OFS_STATUS        4'h7
`define OFS_MASK          4'h8

`define BIT_GLOBAL_HIGH   7
`define BIT_PERIPH_LOW    6
`define BIT_PRIO_MODE     7
`define BIT_PORT_CHANGE   4

`define RST_EDGE_SELECT   4'hf
`define RST_PRIORITY      8'hff
`define CORE_SRC_MASK     8'h1f

`define VEC_HIGH          21'h000008
`define VEC_LOW           21'h000018

`define ST_HIGH_ENTRY     0
`define ST_LOW_ENTRY      1
`define ST_RETURN         2

`endif

//--- rtl/irq_unit_pkg.sv
// types shared by the interrupt unit
// assumes nothing beyond a SystemVerilog compiler
package irq_unit_pkg;
	typedef enum logic [1:0] {LVL_NONE, LVL_HIGH, LVL_LOW, LVL_COMPAT} entry_level_e;
	typedef logic [7:0] byte_t;
endpackage

//--- rtl/pin_sync.sv
// three-flop pin synchroniser with agreement filter
// assumes asynchronous pins and a clock enable that freezes state
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             CORE_CLK,
	input  wire logic             RST,
	input  wire logic             CE,
	input  wire logic [WIDTH-1:0] PIN,
	output logic      [WIDTH-1:0] LEVEL
);
	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else if (CE) begin
			s1 <= PIN;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// level follows once second and third stage agree
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			LEVEL <= '0;
		end else if (CE) begin
			LEVEL <= (s2 & s3) | (LEVEL & (s2 | s3));
		end
	end
endmodule
`default_nettype wire

//--- rtl/port_change_detect.sv
// port-change mismatch detector for the upper four port pins
// assumes synchronised pin levels and a one-cycle port read strobe
`timescale 1ns/1ps
`default_nettype none
module port_change_detect (
	input  wire logic       CORE_CLK,
	input  wire logic       RST,
	input  wire logic       CE,
	input  wire logic [3:0] LEVEL,
	input  wire logic       PORT_READ,
	output logic      [3:0] LATCHED,
	output logic            MISMATCH
);
	// reading the port reloads the latch and ends the mismatch
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			LATCHED <= 4'h0;
		end else if (CE && PORT_READ) begin
			LATCHED <= LEVEL;
		end
	end

	assign MISMATCH = (LEVEL != LATCHED);
endmodule
`default_nettype wire

//--- tb/core_model.sv
// core-side model: return sequencing and hardware stack depth
// assumes the interrupt unit pulses its stack strobes for one cycle
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input  wire logic       CORE_CLK,
	input  wire logic       RST,
	input  wire logic       STACK_PUSH,
	input  wire logic       STACK_POP,
	input  wire logic       RET_REQ,
	input  wire logic [3:0] RET_DELAY,
	output logic            RETURN_EXEC,
	output logic      [4:0] DEPTH
);
	logic [3:0] wait_cnt;
	logic       armed;

	// return instruction after a prompt or slow delay
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			armed <= 1'b0;
			wait_cnt <= 4'h0;
			RETURN_EXEC <= 1'b0;
		end else begin
			RETURN_EXEC <= armed && wait_cnt == 4'h0;
			if (RET_REQ) begin
				armed <= 1'b1;
				wait_cnt <= RET_DELAY;
			end else if (armed && wait_cnt == 4'h0) begin
				armed <= 1'b0;
			end else if (armed) begin
				wait_cnt <= wait_cnt - 4'h1;
			end
		end
	end

	// stack depth follows push on entry and pop on return
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			DEPTH <= 5'h0;
		end else begin
			DEPTH <= DEPTH + 5'(STACK_PUSH) - 5'(STACK_POP);
		end
	end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the two-level interrupt unit
// assumes the core model and the unit's constants header
`timescale 1ns/1ps
`default_nettype none
`include "irq_unit_consts.svh"
module tb_top;
	logic        clk, rst, ce, wr, rd, ret_req, ret_exec, irq, pc_load, push, pop, last_push;
	logic [3:0]  addr, ext_pin, port_pin, ret_delay;
	logic [7:0]  wdata, rdata, lfsr;
	logic [2:0]  evt;
	logic [20:0] pc_vec, last_vec;
	logic [1:0]  lvl, last_lvl;
	logic [4:0]  depth;
	int          errors, comparisons, entries, seen;
	time         t_entry, t0, lat0;

	two_level_irq_unit two_level_irq_unit_i (.CORE_CLK(clk), .RST(rst), .CE(ce), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .EXT_PIN(ext_pin), .PORT_PIN(port_pin),
		.PERIPH_EVT(evt), .RETURN_EXEC(ret_exec), .IRQ(irq), .PC_LOAD(pc_load), .PC_VECTOR(pc_vec),
		.STACK_PUSH(push), .STACK_POP(pop), .ENTRY_LEVEL(lvl));
	core_model core_model_i (.CORE_CLK(clk), .RST(rst), .STACK_PUSH(push), .STACK_POP(pop),
		.RET_REQ(ret_req), .RET_DELAY(ret_delay), .RETURN_EXEC(ret_exec), .DEPTH(depth));

	function automatic logic [7:0] next_rand(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [20:0] exp_vec(input logic pm, input logic hi);
		return (pm && !hi) ? `VEC_LOW : `VEC_HIGH;
	endfunction
	function automatic logic [1:0] exp_lvl(input logic pm, input logic hi);
		return !pm ? 2'h3 : (hi ? 2'h1 : 2'h2);
	endfunction

	task automatic wrap_up;
		if (errors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [20:0] got, input logic [20:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(21'(rdata & m), 21'(e));
	endtask
	task automatic pulse(input logic [2:0] e);
		@(posedge clk);
		evt <= e;
		@(posedge clk);
		evt <= 3'h0;
	endtask
	task automatic do_return(input logic [3:0] d);
		@(posedge clk);
		ret_req <= 1'b1;
		ret_delay <= d;
		@(posedge clk);
		ret_req <= 1'b0;
		repeat (d + 4) @(posedge clk);
	endtask
	task automatic wait_entry(input logic pm, input logic hi);
		int n;
		n = 0;
		while (entries == seen && n < 40) begin
			@(posedge clk);
			n++;
		end
		#1;
		seen++;
		chk(21'(entries), 21'(seen));
		chk(last_vec, exp_vec(pm, hi));
		chk(21'(last_lvl), 21'(exp_lvl(pm, hi)));
		chk(21'(last_push), 21'h1);
	endtask

	// entry monitor: outputs stand one cycle, sampled before the edge updates
	always @(posedge clk) begin
		if (pc_load === 1'b1) begin
			entries++;
			last_vec = pc_vec;
			last_lvl = lvl;
			last_push = push;
			t_entry = $time;
		end
	end

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		wrap_up;
	end

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		{wr, rd, ret_req, addr, ext_pin, port_pin, ret_delay, evt, wdata} = '0;
		errors = 0;
		comparisons = 0;
		entries = 0;
		seen = 0;
		lfsr = 8'h32;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rreg(4'h0, 8'hff, 8'h00);
		rreg(4'h1, 8'hff, 8'h00);
		rreg(4'h4, 8'hff, `RST_PRIORITY);
		rreg(4'h5, 8'h0f, `RST_EDGE_SELECT);
		wreg(4'h9, 8'hff);
		rreg(4'h9, 8'hff, 8'h00);
		for (int i = 0; i < 8; i++) begin
			lfsr = next_rand(lfsr);
			wreg(4'h3, lfsr);
			rreg(4'h3, 8'hff, lfsr);
		end
		// compatibility mode, peripheral source marked low
		wreg(4'h3, 8'h20);
		wreg(4'h4, 8'h00);
		wreg(4'h8, 8'h00);
		pulse(3'h1);
		rreg(4'h2, 8'hff, 8'h20);
		wreg(4'h0, 8'h80);
		repeat (5) @(posedge clk);
		chk(21'(entries), 21'(seen));
		wreg(4'h0, 8'hc0);
		wait_entry(1'b0, 1'b0);
		chk(21'(depth), 21'h1);
		rreg(4'h0, 8'hff, 8'h40);
		chk(21'(irq), 21'h0);
		wreg(4'h8, 8'h07);
		repeat (2) @(posedge clk);
		#1 chk(21'(irq), 21'h1);
		rreg(4'h7, 8'hff, 8'h01);
		repeat (2) @(posedge clk);
		#1 chk(21'(irq), 21'h0);
		wreg(4'h2, 8'h00);
		do_return(4'h0);
		rreg(4'h0, 8'hff, 8'hc0);
		chk(21'(depth), 21'h0);
		rreg(4'h7, 8'hff, 8'h04);
		wreg(4'h7, 8'hff);
		rreg(4'h7, 8'hff, 8'h00);
		// priority mode: low entry, then high preempts
		wreg(4'h1, 8'h80);
		rreg(4'h1, 8'h80, 8'h80);
		wreg(4'h4, 8'h80);
		wreg(4'h3, 8'hc0);
		pulse(3'h2);
		wait_entry(1'b1, 1'b0);
		rreg(4'h0, 8'hff, 8'h80);
		pulse(3'h4);
		wait_entry(1'b1, 1'b1);
		rreg(4'h0, 8'hff, 8'h00);
		wreg(4'h2, 8'h40);
		do_return(4'h3);
		rreg(4'h0, 8'hff, 8'h80);
		chk(21'(entries), 21'(seen));
		wreg(4'h2, 8'h00);
		do_return(4'h0);
		rreg(4'h0, 8'hff, 8'hc0);
		chk(21'(depth), 21'h0);
		// external pins: edge select and fixed latency
		wreg(4'h5, 8'h0d);
		@(posedge clk);
		ext_pin <= 4'h2;
		repeat (10) @(posedge clk);
		rreg(4'h2, 8'hff, 8'h00);
		wreg(4'h4, 8'h83);
		wreg(4'h3, 8'h03);
		@(posedge clk);
		ext_pin <= 4'h3;
		t0 = $time;
		wait_entry(1'b1, 1'b1);
		lat0 = t_entry - t0;
		chk(21'(lat0 >= 60 && lat0 <= 70), 21'h1);
		wreg(4'h2, 8'h00);
		do_return(4'h0);
		@(posedge clk);
		ext_pin <= 4'h1;
		t0 = $time;
		wait_entry(1'b1, 1'b1);
		chk(21'(t_entry - t0), 21'(lat0));
		wreg(4'h2, 8'h00);
		do_return(4'h0);
		// port change mismatch holds the flag until the port is read
		rreg(4'h6, 8'hf0, 8'h00);
		@(posedge clk);
		port_pin <= 4'h5;
		repeat (8) @(posedge clk);
		rreg(4'h2, 8'hff, 8'h10);
		wreg(4'h2, 8'h00);
		rreg(4'h2, 8'hff, 8'h10);
		rreg(4'h6, 8'hf0, 8'h50);
		wreg(4'h2, 8'h00);
		rreg(4'h2, 8'hff, 8'h00);
		// clock enable low: an event pulse must leave no flag behind
		@(posedge clk);
		ce <= 1'b0;
		pulse(3'h1);
		ce <= 1'b1;
		rreg(4'h2, 8'hff, 8'h00);
		wrap_up;
	end
endmodule
`default_nettype wire
